// ---- hw/urp_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module urp_fifo #(
   parameter int WIDTH = 73,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);

   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] count_reg;
   logic [PW:0] count_next;
   logic not_full_reg;
   logic push;
   logic pop;

   // Handshakes on both sides
   assign push = in_valid & not_full_reg;
   assign pop = out_valid & out_ready;
   assign in_ready = not_full_reg;
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rd_ptr_reg];
   assign level = count_reg;

   // Occupancy after this edge
   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   // Storage
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and level
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         not_full_reg <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
         count_reg <= count_next;
         not_full_reg <= (count_next != FULL);
      end
   end

endmodule

// ---- hw/urp_pkg.sv ----
// Shared constants and types for the user request port
package urp_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int DATA_W = 64;
   localparam int MASK_W = 8;
   localparam int CHECK_W = 8;
   localparam int WORD_W = 72;
   localparam int LANES = 18;
   localparam int CMD_W = 3;
   localparam int REG_AW = 4;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = 16;

   // ****************************************
   // Command codes
   // ****************************************
   localparam logic [2:0] CMD_WRITE = 3'h0;
   localparam logic [2:0] CMD_READ = 3'h1;

   // ****************************************
   // Register map and fields
   // ****************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_CMD_COUNT = 4'h8;
   localparam logic [3:0] REG_BAD_COUNT = 4'hc;
   localparam int CTRL_DDR4_BIT = 0;
   localparam int CTRL_ECC_BIT = 1;
   localparam int CTRL_MODE_LSB = 2;
   localparam int CTRL_DM_BIT = 4;
   localparam int CTRL_RECAL_BIT = 5;
   localparam logic [4:0] CTRL_RESET = 5'h10;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_MASK_BIT = 1;
   localparam int STAT_BUSY_BIT = 2;
   localparam int STAT_LEVEL_LSB = 8;

   // DDR4 mask and inversion modes
   typedef enum logic [1:0] {
      URP_MODE_NONE = 2'h0,
      URP_MODE_MASK_WITHOUT_INVERSION = 2'h1,
      URP_MODE_MASK_WITH_READ_INVERSION = 2'h2,
      URP_MODE_INVERSION_ONLY = 2'h3
   } urp_mask_mode_e;

   // Calibration states, Gray from idle through run to done
   typedef enum logic [1:0] {
      URP_CAL_IDLE = 2'b00,
      URP_CAL_RUN = 2'b01,
      URP_CAL_DONE = 2'b11
   } urp_cal_e;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_PS = 40000;
   localparam int DRAM_CLOCK_RATIO = 4;
   localparam int CAL_TIME_NS = 2000;
   localparam int CAL_CYCLES = (CAL_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

// ---- hw/urp_port.sv ----
// Front-end request port of the DRAM controller
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module urp_port #(
   parameter int ADDR_W = 29,
   parameter int CAL_COUNT = urp_pkg::CAL_CYCLES
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [urp_pkg::REG_AW-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [urp_pkg::CMD_W-1:0] req_cmd,
   input wire logic req_auto_close,
   input wire logic req_strobe,
   input wire logic priority_reserved_input,
   output logic req_ready,
   input wire logic [urp_pkg::DATA_W-1:0] wr_data,
   input wire logic [urp_pkg::MASK_W-1:0] wr_mask,
   input wire logic wr_last,
   input wire logic wr_strobe,
   output logic wbuf_ready,
   output logic [urp_pkg::DATA_W-1:0] rd_data,
   output logic rd_valid,
   output logic rd_last,
   output logic front_end_reset,
   output logic training_done,
   output logic dram_cmd_valid,
   output logic [urp_pkg::CMD_W-1:0] dram_cmd_code,
   output logic [ADDR_W-1:0] dram_cmd_addr,
   output logic dram_cmd_a10,
   input wire logic dram_cmd_ready,
   output logic dram_wr_valid,
   output logic [urp_pkg::WORD_W-1:0] dram_wr_word,
   output logic [urp_pkg::LANES-1:0] dram_wr_lane_en,
   output logic dram_wr_last,
   input wire logic dram_wr_ready,
   input wire logic [urp_pkg::DATA_W-1:0] phy_rd_data,
   input wire logic phy_rd_valid,
   input wire logic phy_rd_last
);

   localparam int FW = urp_pkg::DATA_W + urp_pkg::MASK_W + 1;
   localparam int LW = $clog2(urp_pkg::FIFO_DEPTH) + 1;
   localparam logic [15:0] CAL_LAST = 16'(CAL_COUNT - 1);

   // ****************************************
   // Declarations
   // ****************************************
   logic [1:0] rst_sync_reg;
   urp_pkg::urp_cal_e cal_state_reg;
   urp_pkg::urp_cal_e cal_state_next;
   logic [15:0] cal_count_reg;
   logic [4:0] ctrl_reg;
   logic recal_reg;
   logic mask_active_reg;
   logic mask_active_next;
   urp_pkg::urp_mask_mode_e mode;
   logic [urp_pkg::CNT_W-1:0] cmd_count_reg;
   logic [urp_pkg::CNT_W-1:0] bad_count_reg;
   logic accept;
   logic is_column;
   logic slot_next;
   logic [31:0] status;
   logic [FW-1:0] fifo_in;
   logic [FW-1:0] fifo_out;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [LW-1:0] fifo_level;
   logic load_out;
   logic [8:0] byte_en;
   logic [urp_pkg::CHECK_W-1:0] check;
   logic [urp_pkg::LANES-1:0] mem_strobe_en;
   logic [urp_pkg::LANES-1:0] lane_en;

   // ****************************************
   // Reset and calibration
   // ****************************************

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_sync_reg <= 2'b11;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b0};
      end
   end
   assign front_end_reset = rst_sync_reg[1];

   always_comb begin
      cal_state_next = cal_state_reg;
      case (cal_state_reg)
         urp_pkg::URP_CAL_IDLE: begin
            cal_state_next = urp_pkg::URP_CAL_RUN;
         end
         urp_pkg::URP_CAL_RUN: begin
            if (cal_count_reg == CAL_LAST) begin
               cal_state_next = urp_pkg::URP_CAL_DONE;
            end
         end
         urp_pkg::URP_CAL_DONE: begin
            if (recal_reg) begin
               cal_state_next = urp_pkg::URP_CAL_IDLE;
            end
         end
         default: begin
            cal_state_next = urp_pkg::URP_CAL_IDLE;
         end
      endcase
   end

   // State, counter and done flag
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cal_state_reg <= urp_pkg::URP_CAL_IDLE;
         cal_count_reg <= '0;
         training_done <= 1'b0;
      end else begin
         cal_state_reg <= cal_state_next;
         if (cal_state_reg == urp_pkg::URP_CAL_RUN) begin
            cal_count_reg <= cal_count_reg + 1'b1;
         end else begin
            cal_count_reg <= '0;
         end
         training_done <= (cal_state_next == urp_pkg::URP_CAL_DONE);
      end
   end

   // ****************************************
   // Register port
   // ****************************************
   assign mode = urp_pkg::urp_mask_mode_e'(ctrl_reg[urp_pkg::CTRL_MODE_LSB +: 2]);

   // where the byte mask is honoured
   always_comb begin
      if (ctrl_reg[urp_pkg::CTRL_DDR4_BIT]) begin
         mask_active_next = ctrl_reg[urp_pkg::CTRL_ECC_BIT] |
            (mode == urp_pkg::URP_MODE_MASK_WITHOUT_INVERSION) |
            (mode == urp_pkg::URP_MODE_MASK_WITH_READ_INVERSION);
      end else begin
         mask_active_next = ctrl_reg[urp_pkg::CTRL_DM_BIT];
      end
   end

   // Control writes and recalibrate pulse
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg <= urp_pkg::CTRL_RESET;
         recal_reg <= 1'b0;
         mask_active_reg <= 1'b0;
      end else begin
         recal_reg <= 1'b0;
         if (reg_write && reg_addr == urp_pkg::REG_CTRL) begin
            ctrl_reg <= reg_wdata[4:0];
            recal_reg <= reg_wdata[urp_pkg::CTRL_RECAL_BIT];
         end
         mask_active_reg <= mask_active_next;
      end
   end

   // Status word
   always_comb begin
      status = '0;
      status[urp_pkg::STAT_DONE_BIT] = training_done;
      status[urp_pkg::STAT_MASK_BIT] = mask_active_reg;
      status[urp_pkg::STAT_BUSY_BIT] = dram_cmd_valid;
      status[urp_pkg::STAT_LEVEL_LSB +: LW] = fifo_level;
   end

   // Read data for one cycle only; unmapped reads zero
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_read) begin
            case (reg_addr)
               urp_pkg::REG_CTRL: reg_rdata <= {27'h0, ctrl_reg};
               urp_pkg::REG_STATUS: reg_rdata <= status;
               urp_pkg::REG_CMD_COUNT: reg_rdata <= {16'h0, cmd_count_reg};
               urp_pkg::REG_BAD_COUNT: reg_rdata <= {16'h0, bad_count_reg};
               default: reg_rdata <= '0;
            endcase
         end
      end
   end

   // ****************************************
   // Command path
   // ****************************************

   // taken on strobe while ready; priority ignored
   assign accept = req_strobe & req_ready;
   assign is_column = (req_cmd == urp_pkg::CMD_WRITE) | (req_cmd == urp_pkg::CMD_READ);
   assign slot_next = accept | (dram_cmd_valid & ~dram_cmd_ready);

   // ready only with slot free after calibration
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         req_ready <= 1'b0;
         dram_cmd_valid <= 1'b0;
      end else begin
         req_ready <= (cal_state_next == urp_pkg::URP_CAL_DONE) & ~slot_next;
         dram_cmd_valid <= slot_next;
      end
   end

   // command sampled with address; refused ones stay out
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         dram_cmd_code <= '0;
         dram_cmd_addr <= '0;
         dram_cmd_a10 <= 1'b0;
      end else if (accept) begin
         dram_cmd_code <= req_cmd;
         dram_cmd_addr <= req_addr;
         dram_cmd_a10 <= req_auto_close & is_column;
      end
   end

   // Accepted and unknown command counters; write clears
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cmd_count_reg <= '0;
         bad_count_reg <= '0;
      end else begin
         if (reg_write && reg_addr == urp_pkg::REG_CMD_COUNT) begin
            cmd_count_reg <= '0;
         end else if (accept) begin
            cmd_count_reg <= cmd_count_reg + 1'b1;
         end
         if (reg_write && reg_addr == urp_pkg::REG_BAD_COUNT) begin
            bad_count_reg <= '0;
         end else if (accept && !is_column) begin
            bad_count_reg <= bad_count_reg + 1'b1;
         end
      end
   end

   // ****************************************
   // Write data path
   // ****************************************

   // last marker stored with its word
   assign fifo_in = {wr_last, wr_mask, wr_data};

   // transfer on write strobe and buffer ready
   urp_fifo #(
      .WIDTH(FW),
      .DEPTH(urp_pkg::FIFO_DEPTH)
   ) u_wbuf (
      .clock(clock),
      .resetn(resetn),
      .in_valid(wr_strobe),
      .in_ready(wbuf_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out),
      .level(fifo_level)
   );

   // Drain into output stage, stalled by the DRAM side
   assign fifo_out_ready = ~dram_wr_valid | dram_wr_ready;
   assign load_out = fifo_out_valid & fifo_out_ready;

   // Per-byte enables and check bits
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi++) begin : g_byte
         if (gi < 8) begin : g_data
            assign byte_en[gi] = ~mask_active_reg | ~fifo_out[urp_pkg::DATA_W + gi];
            assign check[gi] = ^fifo_out[8*gi +: 8];
         end else begin : g_check
            assign byte_en[gi] = ctrl_reg[urp_pkg::CTRL_ECC_BIT];
         end
         // Low nibble by strobe gi, high nibble by strobe gi+9
         assign mem_strobe_en[gi] = byte_en[gi];
         assign mem_strobe_en[gi + 9] = byte_en[gi];
         assign lane_en[2*gi] = mem_strobe_en[gi];
         assign lane_en[2*gi + 1] = mem_strobe_en[gi + 9];
      end
   endgenerate

   // Output stage toward the DRAM side
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         dram_wr_valid <= 1'b0;
         dram_wr_word <= '0;
         dram_wr_lane_en <= '0;
         dram_wr_last <= 1'b0;
      end else begin
         if (load_out) begin
            dram_wr_valid <= 1'b1;
         end else if (dram_wr_ready) begin
            dram_wr_valid <= 1'b0;
         end
         if (load_out) begin
            dram_wr_word <= {check & {8{ctrl_reg[urp_pkg::CTRL_ECC_BIT]}},
                             fifo_out[urp_pkg::DATA_W-1:0]};
            dram_wr_lane_en <= lane_en;
            dram_wr_last <= fifo_out[FW-1];
         end
      end
   end

   // ****************************************
   // Read return path
   // ****************************************

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rd_valid <= 1'b0;
         rd_last <= 1'b0;
         rd_data <= '0;
      end else begin
         rd_valid <= phy_rd_valid;
         // last only on a valid word
         rd_last <= phy_rd_valid & phy_rd_last;
         if (phy_rd_valid) begin
            rd_data <= phy_rd_data;
         end
      end
   end

endmodule

// ---- verification/urp_port_tb.sv ----
// Self-checking bench of the user request port
`timescale 1ns/1ps
module urp_port_tb;
   typedef struct packed {logic [2:0] cmd; logic close; logic [28:0] addr; logic a10;} urp_row_s;
   // Requests beside the column flag they give
   urp_row_s rows [10] = '{
      '{3'h0, 1'b1, 29'h0000_0008, 1'b1}, '{3'h1, 1'b1, 29'h1fff_fff8, 1'b1},
      '{3'h0, 1'b0, 29'h0abc_d010, 1'b0}, '{3'h1, 1'b0, 29'h1555_5550, 1'b0},
      '{3'h2, 1'b1, 29'h0000_0100, 1'b0}, '{3'h3, 1'b1, 29'h0000_0200, 1'b0},
      '{3'h4, 1'b1, 29'h0000_0400, 1'b0}, '{3'h5, 1'b1, 29'h0000_0800, 1'b0},
      '{3'h6, 1'b1, 29'h0000_1000, 1'b0}, '{3'h7, 1'b1, 29'h0000_2000, 1'b0}};
   logic clock = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0, go = 1'b0;
   logic close_in = 1'b0, c_ready = 1'b0, w_ready = 1'b0, wr_last = 1'b0, wr_strobe = 1'b0;
   logic p_valid = 1'b0, p_last = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [2:0] cmd_in = 3'h0, req_cmd, c_code;
   logic [28:0] addr_in = 29'h0, req_addr, c_addr;
   logic [63:0] wr_data = 64'h0, p_data = 64'h0, rd_data;
   logic [7:0] wr_mask = 8'h0;
   logic close, strobe, pri, ready, wbuf_ready, rd_valid, rd_last, fe_rst, done;
   logic c_valid, c_a10, w_valid, w_last;
   logic [71:0] w_word;
   logic [17:0] w_lane;
   int n_errors = 0, n_tests = 0;

   urp_port #(.CAL_COUNT(4)) dut_u (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .req_addr(req_addr), .req_cmd(req_cmd), .req_auto_close(close), .req_strobe(strobe),
      .priority_reserved_input(pri), .req_ready(ready), .wr_data(wr_data), .wr_mask(wr_mask),
      .wr_last(wr_last), .wr_strobe(wr_strobe), .wbuf_ready(wbuf_ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .rd_last(rd_last), .front_end_reset(fe_rst), .training_done(done),
      .dram_cmd_valid(c_valid), .dram_cmd_code(c_code), .dram_cmd_addr(c_addr),
      .dram_cmd_a10(c_a10), .dram_cmd_ready(c_ready), .dram_wr_valid(w_valid),
      .dram_wr_word(w_word), .dram_wr_lane_en(w_lane), .dram_wr_last(w_last),
      .dram_wr_ready(w_ready), .phy_rd_data(p_data), .phy_rd_valid(p_valid), .phy_rd_last(p_last));
   urp_user_model user_u (.clock(clock), .resetn(resetn), .go(go), .cmd_in(cmd_in),
      .addr_in(addr_in), .close_in(close_in), .req_ready(ready), .training_done(done),
      .req_addr(req_addr), .req_cmd(req_cmd), .req_auto_close(close), .req_strobe(strobe),
      .priority_reserved_input(pri));

   // 25 MHz clock
   always #20 clock = ~clock;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [63:0] dat(int i);
      return {8{8'(i * 37)}} ^ 64'hf0e1_d2c3_b4a5_9687;
   endfunction
   function automatic logic [15:0] spread(logic [7:0] e);
      for (int k = 0; k < 8; k++) spread[2*k +: 2] = {2{e[k]}};
   endfunction
   function automatic logic [7:0] par(logic [63:0] d);
      for (int k = 0; k < 8; k++) par[k] = ^d[8*k +: 8];
   endfunction
   task automatic chk(input string name, input logic [71:0] seen, input logic [71:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      chk("reg_rdata", reg_rdata, exp);
   endtask
   task automatic issue(int i);
      @(posedge clock);
      cmd_in <= rows[i].cmd;
      addr_in <= rows[i].addr;
      close_in <= rows[i].close;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
   endtask
   task automatic wait_done();
      for (int k = 0; k < 40 && done !== 1'b1; k++) @(negedge clock);
   endtask
   // Word i with its mask and last marker
   task automatic put(int i);
      wr_data <= dat(i);
      wr_mask <= 8'(i * 29);
      wr_last <= (i % 4 == 3);
   endtask
   // Fill the buffer until refused, then drain with stalls
   task automatic words(input logic [31:0] ctrl, input logic act);
      int n, m, s;
      logic ecc;
      n = 0;
      m = 0;
      s = 0;
      ecc = ctrl[urp_pkg::CTRL_ECC_BIT];
      reg_wr(urp_pkg::REG_CTRL, ctrl);
      put(0);
      wr_strobe <= 1'b1;
      while (s < 3) begin
         @(posedge clock);
         if (wbuf_ready === 1'b1) begin
            n++;
            put(n);
         end else begin
            s++;
         end
      end
      wr_strobe <= 1'b0;
      wr_data <= ~wr_data;
      rd_chk(urp_pkg::REG_STATUS, {19'h0, 5'h10, 6'h0, act, 1'b1});
      // Stall every other cycle; ready drops once the last word has gone
      for (int k = 0; k < 200 && m < n; k++) begin
         @(posedge clock);
         if (w_valid === 1'b1 && w_ready === 1'b1) begin
            chk("dram_wr_word", w_word, {ecc ? par(dat(m)) : 8'h00, dat(m)});
            chk("lane_en", w_lane, {{2{ecc}}, act ? spread(~8'(m * 29)) : 16'hffff});
            chk("dram_wr_last", w_last, m % 4 == 3);
            m++;
         end
         w_ready <= !w_ready && m < n;
      end
      chk("words drained", m, n);
   endtask
   task automatic results();
      if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog
   initial begin
      #800000;
      n_errors++;
      results();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (16) @(posedge clock);
      chk("front_end_reset", fe_rst, 1'b1);
      chk("training_done", done, 1'b0);
      resetn <= 1'b1;
      repeat (2) @(negedge clock);
      chk("front_end_reset", fe_rst, 1'b1);
      chk("req_ready", ready, 1'b0);
      @(negedge clock);
      chk("front_end_reset", fe_rst, 1'b0);
      wait_done();
      chk("training_done", done, 1'b1);
      chk("req_ready", ready, 1'b1);
      rd_chk(urp_pkg::REG_CTRL, 32'h10);
      rd_chk(4'h2, 32'h0);
      // Each row issued while the slot before it still stalls
      issue(0);
      for (int i = 0; i < 10; i++) begin
         for (int k = 0; k < 40 && c_valid !== 1'b1; k++) @(negedge clock);
         chk("dram_cmd_code", c_code, rows[i].cmd);
         chk("dram_cmd_addr", c_addr, rows[i].addr);
         chk("dram_cmd_a10", c_a10, rows[i].a10);
         if (i < 9) issue(i + 1);
         repeat (2) @(negedge clock);
         chk("dram_cmd_code", c_code, rows[i].cmd);
         chk("req_ready", ready, 1'b0);
         @(posedge clock);
         c_ready <= 1'b1;
         @(posedge clock);
         c_ready <= 1'b0;
         @(negedge clock);
      end
      rd_chk(urp_pkg::REG_CMD_COUNT, 32'h0a);
      rd_chk(urp_pkg::REG_BAD_COUNT, 32'h06);
      reg_wr(urp_pkg::REG_BAD_COUNT, 32'h0);
      rd_chk(urp_pkg::REG_BAD_COUNT, 32'h0);
      // DDR4 with check bits, DDR4 plain, DDR3 with mask, DDR4 mask with read inversion
      words(32'h07, 1'b1);
      words(32'h01, 1'b0);
      words(32'h10, 1'b1);
      words(32'h09, 1'b1);
      // Burst of four returned words, then idle
      for (int k = 0; k < 7; k++) begin
         @(posedge clock);
         p_valid <= (k < 4);
         p_last <= (k == 3);
         p_data <= {16{4'(k)}};
         @(negedge clock);
         if (k > 0) begin
            chk("rd_valid", rd_valid, k < 5);
            chk("rd_last", rd_last, k == 4);
            if (k < 5) chk("rd_data", rd_data, {16{4'(k - 1)}});
         end
      end
      // Recalibrate drops done and ready until training ends again
      reg_wr(urp_pkg::REG_CTRL, 32'h30);
      repeat (2) @(negedge clock);
      chk("training_done", done, 1'b0);
      chk("req_ready", ready, 1'b0);
      wait_done();
      chk("training_done", done, 1'b1);
      chk("req_ready", ready, 1'b1);
      // Second reset in mid-run
      @(posedge clock);
      resetn <= 1'b0;
      @(negedge clock);
      chk("front_end_reset", fe_rst, 1'b1);
      chk("training_done", done, 1'b0);
      @(posedge clock);
      resetn <= 1'b1;
      wait_done();
      rd_chk(urp_pkg::REG_CTRL, 32'h10);
      results();
   end
endmodule

// ---- verification/urp_props.sv ----
// Checker of the user request port
`timescale 1ns/1ps
module urp_props #(
   parameter int ADDR_W = 29
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [2:0] req_cmd,
   input wire logic req_auto_close,
   input wire logic req_strobe,
   input wire logic req_ready,
   input wire logic training_done,
   input wire logic front_end_reset,
   input wire logic dram_cmd_valid,
   input wire logic [2:0] dram_cmd_code,
   input wire logic [ADDR_W-1:0] dram_cmd_addr,
   input wire logic dram_cmd_a10,
   input wire logic dram_cmd_ready,
   input wire logic dram_wr_valid,
   input wire logic [17:0] dram_wr_lane_en,
   input wire logic [63:0] phy_rd_data,
   input wire logic phy_rd_valid,
   input wire logic phy_rd_last,
   input wire logic [63:0] rd_data,
   input wire logic rd_valid,
   input wire logic rd_last
);
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   a_take_slot: assert property (
      req_strobe && req_ready |=> dram_cmd_valid && !req_ready)
      else $error("taken request missing from slot");
   a_cmd_fields: assert property (
      req_strobe && req_ready |=> dram_cmd_code == $past(req_cmd)
      && dram_cmd_addr == $past(req_addr))
      else $error("slot fields differ from request");
   a_auto_close: assert property (
      req_strobe && req_ready |=>
      dram_cmd_a10 == ($past(req_auto_close) && $past(req_cmd) < 3'h2))
      else $error("column flag wrong");
   a_cmd_stands: assert property (
      dram_cmd_valid && !dram_cmd_ready |=> dram_cmd_valid
      && $stable(dram_cmd_code) && $stable(dram_cmd_addr))
      else $error("slot changed while stalled");
   a_ready_done: assert property (
      req_ready |-> training_done && !front_end_reset)
      else $error("ready before training done");
   // Read valid follows the returned word
   a_rd_valid: assert property (
      1'b1 |=> rd_valid == $past(phy_rd_valid)
      && (!rd_valid || rd_data == $past(phy_rd_data)))
      else $error("read valid or data wrong");
   a_rd_last: assert property (
      1'b1 |=> rd_last == $past(phy_rd_last && phy_rd_valid))
      else $error("read last wrong");
   a_lane_pairs: assert property (
      dram_wr_valid |-> ((dram_wr_lane_en >> 1) & 18'h15555) == (dram_wr_lane_en & 18'h15555))
      else $error("lane pair enables differ");
endmodule

bind urp_port urp_props #(.ADDR_W(ADDR_W)) props_u (.clock(clock), .resetn(resetn),
   .req_addr(req_addr), .req_cmd(req_cmd), .req_auto_close(req_auto_close),
   .req_strobe(req_strobe), .req_ready(req_ready), .training_done(training_done),
   .front_end_reset(front_end_reset), .dram_cmd_valid(dram_cmd_valid),
   .dram_cmd_code(dram_cmd_code), .dram_cmd_addr(dram_cmd_addr), .dram_cmd_a10(dram_cmd_a10),
   .dram_cmd_ready(dram_cmd_ready), .dram_wr_valid(dram_wr_valid),
   .dram_wr_lane_en(dram_wr_lane_en), .phy_rd_data(phy_rd_data), .phy_rd_valid(phy_rd_valid),
   .phy_rd_last(phy_rd_last), .rd_data(rd_data), .rd_valid(rd_valid), .rd_last(rd_last));

// ---- verification/urp_user_model.sv ----
// User-side request source for the port bench
`timescale 1ns/1ps
module urp_user_model (
   input wire logic clock,
   input wire logic resetn,
   input wire logic go,
   input wire logic [2:0] cmd_in,
   input wire logic [28:0] addr_in,
   input wire logic close_in,
   input wire logic req_ready,
   input wire logic training_done,
   output logic [28:0] req_addr,
   output logic [2:0] req_cmd,
   output logic req_auto_close,
   output logic req_strobe,
   output logic priority_reserved_input
);
   assign priority_reserved_input = 1'b0;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         req_strobe <= 1'b0;
         req_cmd <= 3'h0;
         req_addr <= 29'h0;
         req_auto_close <= 1'b0;
      end else if (req_strobe && req_ready) begin
         req_strobe <= 1'b0;
         req_cmd <= ~req_cmd; // Released lines show the inverse
         req_addr <= ~req_addr;
         req_auto_close <= ~req_auto_close;
      end else if (go && training_done && !req_strobe) begin
         req_strobe <= 1'b1;
         req_cmd <= cmd_in;
         req_addr <= addr_in;
         req_auto_close <= close_in;
      end
   end
endmodule
